// ===== slc_regs_map.svh
// Purpose: Offsets, field positions and reset values of the slot capability and control bank
// Assumes: Byte addresses in PCI configuration space, dword aligned
// Notes:   Included by the register bank and its assertion module
`ifndef SLC_REGS_MAP_SVH
`define SLC_REGS_MAP_SVH

`define SLC_OFS_SLOT_CAP      12'h0b4
`define SLC_OFS_SLOT_CTL      12'h0b8

`define SLC_RST_SLOT_CAP      32'h0004_0000
`define SLC_RST_SLOT_CTL      16'h01c0

`define SLC_CAP_SLOT_NUM_HI   31
`define SLC_CAP_SLOT_NUM_LO   19
`define SLC_CAP_NO_CMD_CMPL   18
`define SLC_CAP_SCALE_HI      16
`define SLC_CAP_SCALE_LO      15
`define SLC_CAP_VALUE_HI      14
`define SLC_CAP_VALUE_LO      7

`define SLC_CTL_PWR_IND_HI    9
`define SLC_CTL_PWR_IND_LO    8
`define SLC_CTL_ATT_IND_HI    7
`define SLC_CTL_ATT_IND_LO    6
`define SLC_CTL_PRES_NOTIFY   3
`define SLC_STS_PRES_CHANGED  19
`define SLC_STS_PRES_STATE    22

`define SLC_RST_NO_CMD_CMPL   1'b1
`define SLC_RST_SCALE         2'h0
`define SLC_RST_VALUE         8'h00
`define SLC_RST_PWR_IND       2'h1
`define SLC_ATT_IND_OFF       2'h3

`endif

// ===== slc_pkg.sv
// Purpose: Types shared by the slot register bank and its message generator
// Assumes: Nothing beyond the map header
// Notes:   Message codes are local to this port's link layer
package slc_pkg;

    typedef enum logic [1:0] {
        SLC_MSG_POWER_LIMIT = 2'h0,
        SLC_MSG_IND_ON      = 2'h1,
        SLC_MSG_IND_BLINK   = 2'h2,
        SLC_MSG_IND_OFF     = 2'h3
    } slc_msg_code_t;

    typedef enum logic [1:0] {
        SLC_IND_RESERVED = 2'h0,
        SLC_IND_ON       = 2'h1,
        SLC_IND_BLINK    = 2'h2,
        SLC_IND_OFF      = 2'h3
    } slc_ind_t;

endpackage

// ===== slc_msg_if.sv
// Purpose: Carries message requests from the register bank to the message generator
// Assumes: Both ends on clk_sys
// Notes:   Requests are one-cycle pulses, never back-pressured
`timescale 1ns/100ps
interface slc_msg_if;
    import slc_pkg::*;
    logic           req_limit;
    logic           req_ind;
    slc_ind_t       ind_state;
    logic [1:0]     limit_scale;
    logic [7:0]     limit_value;

    modport regs (output req_limit, req_ind, ind_state, limit_scale, limit_value);
    modport gen  (input  req_limit, req_ind, ind_state, limit_scale, limit_value);
endinterface

// ===== slc_msg_gen.sv
// Purpose: Turns register-bank requests into slot messages toward the link
// Assumes: At most one request per cycle; limit wins if both ever coincide
// Notes:   One message per cycle, no stall, so control writes never wait
`timescale 1ns/100ps
module slc_msg_gen
    import slc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Requests
    slc_msg_if.gen             req,
    // Link message port
    output logic               msg_valid,
    output slc_msg_code_t      msg_code,
    output logic [9:0]         msg_payload
);

    function automatic slc_msg_code_t ind_code(input slc_ind_t s);
        case (s)
            SLC_IND_BLINK: ind_code = SLC_MSG_IND_BLINK;
            SLC_IND_OFF:   ind_code = SLC_MSG_IND_OFF;
            default:       ind_code = SLC_MSG_IND_ON;
        endcase
    endfunction

    // Registered outputs, so the link sees clean data one cycle after the write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msg_valid   <= 1'b0;
            msg_code    <= SLC_MSG_POWER_LIMIT;
            msg_payload <= 10'h000;
        end else begin
            msg_valid <= req.req_limit | req.req_ind;
            if (req.req_limit) begin
                msg_code    <= SLC_MSG_POWER_LIMIT;
                msg_payload <= {req.limit_scale, req.limit_value};
            end else if (req.req_ind) begin
                msg_code    <= ind_code(req.ind_state);
                msg_payload <= 10'h000;
            end
        end
    end

endmodule

// ===== slc_slot_regs.sv
// Purpose: Slot capability and slot control registers of a root port, with presence change tracking
// Assumes: Configuration accesses are one-cycle strobes with dword byte addresses
// Notes:   Hot-plug and attention features are hardwired off; presence change notify has its own enable
`timescale 1ns/100ps
`include "slc_regs_map.svh"
module slc_slot_regs
    import slc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Configuration access
    input  wire logic          cfg_wr_en,
    input  wire logic          cfg_rd_en,
    input  wire logic [11:0]   cfg_addr,
    input  wire logic [3:0]    cfg_byte_en,
    input  wire logic [31:0]   cfg_wdata,
    output logic [31:0]        cfg_rdata,
    output logic               cfg_rd_valid,
    // Slot pin and notification
    input  wire logic          presence_detect_pin,
    output logic               presence_notify,
    // Link messages
    output logic               msg_valid,
    output slc_msg_code_t      msg_code,
    output logic [9:0]         msg_payload
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic           hit_cap;
    logic           hit_ctl;
    logic           wr_cap;
    logic           wr_ctl;

    // Dword match; the two low address bits never select a register
    function automatic logic dword_hit(input logic [11:0] addr, input logic [11:0] ofs);
        dword_hit = (addr[11:2] == ofs[11:2]);
    endfunction

    always_comb begin
        hit_cap = dword_hit(cfg_addr, `SLC_OFS_SLOT_CAP);
        hit_ctl = dword_hit(cfg_addr, `SLC_OFS_SLOT_CTL);
        wr_cap  = cfg_wr_en & hit_cap & (|cfg_byte_en);
        wr_ctl  = cfg_wr_en & hit_ctl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot capabilities, write-once

    logic [12:0]    physical_slot_number;
    logic           no_cmd_complete_support;
    logic [1:0]     power_limit_scale;
    logic [7:0]     power_limit_value;
    logic           cap_locked;
    logic           cap_take;
    logic [9:0]     next_limit;

    // Byte-enable merge of scale and value; the register and its message share it
    function automatic logic [9:0] merge_limit(input logic [3:0] be, input logic [31:0] wd, input logic [9:0] cur);
        logic [9:0] m;
        m = cur;
        if (be[2]) begin
            m[9] = wd[`SLC_CAP_SCALE_HI];
        end
        if (be[1]) begin
            m[8:1] = wd[`SLC_CAP_SCALE_LO:8];
        end
        if (be[0]) begin
            m[0] = wd[`SLC_CAP_VALUE_LO];
        end
        merge_limit = m;
    endfunction

    // Software programs a chassis-unique number; hardware just keeps it
    assign cap_take = wr_cap & ~cap_locked;

    assign next_limit = merge_limit(cfg_byte_en, cfg_wdata, {power_limit_scale, power_limit_value});

    // Whole register locks on the first write; a later partial write cannot fill gaps
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cap_locked              <= 1'b0;
            physical_slot_number    <= 13'h0000;
            no_cmd_complete_support <= `SLC_RST_NO_CMD_CMPL;
            power_limit_scale       <= `SLC_RST_SCALE;
            power_limit_value       <= `SLC_RST_VALUE;
        end else if (cap_take) begin
            cap_locked <= 1'b1;
            {power_limit_scale, power_limit_value} <= next_limit;
            if (cfg_byte_en[3]) begin
                physical_slot_number[12:5] <= cfg_wdata[31:24];
            end
            if (cfg_byte_en[2]) begin
                physical_slot_number[4:0] <= cfg_wdata[23:19];
                // Control writes never stall, so advertising one stays legal
                no_cmd_complete_support <= cfg_wdata[`SLC_CAP_NO_CMD_CMPL];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slot control

    slc_ind_t       power_indicator_control;
    logic           presence_change_notify_enable;
    logic           ind_write;
    slc_ind_t       next_ind;

    always_comb begin
        next_ind  = slc_ind_t'(cfg_wdata[`SLC_CTL_PWR_IND_HI:`SLC_CTL_PWR_IND_LO]);
        // Reserved code is dropped so the state always names a real indicator
        ind_write = wr_ctl & cfg_byte_en[1] & (next_ind != SLC_IND_RESERVED);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            power_indicator_control <= slc_ind_t'(`SLC_RST_PWR_IND);
        end else if (ind_write) begin
            power_indicator_control <= next_ind;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            presence_change_notify_enable <= 1'b0;
        end else if (wr_ctl & cfg_byte_en[0]) begin
            presence_change_notify_enable <= cfg_wdata[`SLC_CTL_PRES_NOTIFY];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Presence detect: three flops, a change counts once the last two agree

    logic [2:0]     pres_sync;
    logic           presence_state;
    logic           presence_changed_flag;
    logic           pres_event;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pres_sync <= 3'h0;
        end else begin
            pres_sync <= {pres_sync[1:0], presence_detect_pin};
        end
    end

    assign pres_event = (pres_sync[1] == pres_sync[2]) & (pres_sync[2] != presence_state);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            presence_state <= 1'b0;
        end else if (pres_event) begin
            presence_state <= pres_sync[2];
        end
    end

    // A change in the clearing cycle keeps the flag set
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            presence_changed_flag <= 1'b0;
        end else if (pres_event) begin
            presence_changed_flag <= 1'b1;
        end else if (wr_ctl & cfg_byte_en[2] & cfg_wdata[`SLC_STS_PRES_CHANGED]) begin
            presence_changed_flag <= 1'b0;
        end
    end

    assign presence_notify = presence_changed_flag & presence_change_notify_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0]    cap_word;
    logic [31:0]    ctl_word;

    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[`SLC_CAP_SLOT_NUM_HI:`SLC_CAP_SLOT_NUM_LO] = physical_slot_number;
        cap_word[`SLC_CAP_NO_CMD_CMPL]                     = no_cmd_complete_support;
        cap_word[`SLC_CAP_SCALE_HI:`SLC_CAP_SCALE_LO]      = power_limit_scale;
        cap_word[`SLC_CAP_VALUE_HI:`SLC_CAP_VALUE_LO]      = power_limit_value;
        ctl_word = 32'h0000_0000;
        ctl_word[`SLC_CTL_PWR_IND_HI:`SLC_CTL_PWR_IND_LO]  = power_indicator_control;
        ctl_word[`SLC_CTL_ATT_IND_HI:`SLC_CTL_ATT_IND_LO]  = `SLC_ATT_IND_OFF;
        ctl_word[`SLC_CTL_PRES_NOTIFY]                     = presence_change_notify_enable;
        ctl_word[`SLC_STS_PRES_CHANGED]                    = presence_changed_flag;
        ctl_word[`SLC_STS_PRES_STATE]                      = presence_state;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata    <= 32'h0000_0000;
            cfg_rd_valid <= 1'b0;
        end else begin
            cfg_rd_valid <= cfg_rd_en;
            if (cfg_rd_en) begin
                cfg_rdata <= hit_cap ? cap_word : (hit_ctl ? ctl_word : 32'h0000_0000);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Messages

    slc_msg_if msg_req ();

    assign msg_req.req_limit   = cap_take & (|cfg_byte_en[2:0]);
    assign msg_req.req_ind     = ind_write;
    assign msg_req.ind_state   = next_ind;
    assign msg_req.limit_scale = next_limit[9:8];
    assign msg_req.limit_value = next_limit[7:0];

    slc_msg_gen u_msg_gen (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .req         (msg_req),
        .msg_valid   (msg_valid),
        .msg_code    (msg_code),
        .msg_payload (msg_payload)
    );

endmodule

// ===== slc_slot_regs_props.sv
// Purpose: Port-level assertions for the slot register bank
// Assumes: One clock, async active-low reset
// Notes:   Write-once lock is tracked here from the write strobes alone
`timescale 1ns/100ps
`include "slc_regs_map.svh"
module slc_slot_regs_props
    import slc_pkg::*;
(
    // Clock and reset
    input wire logic          clk_sys,
    input wire logic          rstn,
    // Configuration access
    input wire logic          cfg_wr_en,
    input wire logic          cfg_rd_en,
    input wire logic [11:0]   cfg_addr,
    input wire logic [3:0]    cfg_byte_en,
    input wire logic [31:0]   cfg_wdata,
    input wire logic [31:0]   cfg_rdata,
    input wire logic          cfg_rd_valid,
    // Slot pin and notification
    input wire logic          presence_detect_pin,
    input wire logic          presence_notify,
    // Link messages
    input wire logic          msg_valid,
    input wire slc_msg_code_t msg_code,
    input wire logic [9:0]    msg_payload
);
    logic       cap_done;
    logic       cap_sel;
    logic       ctl_sel;
    logic [9:0] wr_limit;
    logic [1:0] wr_ind;
    assign cap_sel  = {cfg_addr[11:2], 2'b00} == `SLC_OFS_SLOT_CAP;
    assign ctl_sel  = {cfg_addr[11:2], 2'b00} == `SLC_OFS_SLOT_CTL;
    assign wr_limit = cfg_wdata[16:7];
    assign wr_ind   = cfg_wdata[9:8];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cap_done <= 1'b0;
        end else if (cfg_wr_en && cap_sel && cfg_byte_en != 4'h0) begin
            cap_done <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence cap_wr_s; cfg_wr_en && cap_sel; endsequence
    sequence ind_wr_s; cfg_wr_en && ctl_sel && cfg_byte_en[1]; endsequence
    sequence ctl_rd_s; cfg_rd_en && ctl_sel; endsequence
    limit_msg_a: assert property (cap_wr_s ##0 (!cap_done && cfg_byte_en == 4'hf) |=>
        msg_valid && msg_code == SLC_MSG_POWER_LIMIT && msg_payload == $past(wr_limit)) else $error("no limit msg");
    cap_lock_a: assert property (cap_wr_s ##0 cap_done |=> !msg_valid) else $error("msg after lock");
    ind_msg_a: assert property (ind_wr_s ##0 wr_ind != 2'h0 |=>
        msg_valid && msg_code == $past(wr_ind) && msg_payload == 10'h000) else $error("bad ind msg");
    ind_rsv_a: assert property (ind_wr_s ##0 wr_ind == 2'h0 |=> !msg_valid) else $error("rsv ind msg");
    msg_quiet_a: assert property (!cfg_wr_en |=> !msg_valid) else $error("stray msg");
    cap_ro_a: assert property (cfg_rd_en && cap_sel |=> cfg_rd_valid && cfg_rdata[6:0] == 7'h00)
        else $error("cap ro bits");
    ctl_ro_a: assert property (ctl_rd_s |=> cfg_rd_valid && cfg_rdata[7:4] == 4'hc && cfg_rdata[0] == 1'b0)
        else $error("ctl ro bits");
    notify_and_a: assert property (ctl_rd_s |=> (cfg_rdata[19] && cfg_rdata[3]) == $past(presence_notify))
        else $error("notify mismatch");
endmodule
bind slc_slot_regs slc_slot_regs_props u_props (.clk_sys(clk_sys), .rstn(rstn), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .presence_detect_pin(presence_detect_pin),
    .presence_notify(presence_notify), .msg_valid(msg_valid), .msg_code(msg_code), .msg_payload(msg_payload));

// ===== slc_link_peer.sv
// Purpose: Far-end link peer that logs slot messages
// Assumes: At most one message per cycle, never stalled
// Notes:   Keeps only the latest message and a count, enough for the bench
`timescale 1ns/100ps
module slc_link_peer
    import slc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Messages from the port
    input  wire logic          msg_valid,
    input  wire slc_msg_code_t msg_code,
    input  wire logic [9:0]    msg_payload,
    // Log
    output int                 msg_count,
    output slc_msg_code_t      last_code,
    output logic [9:0]         last_payload
);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msg_count    <= 0;
            last_code    <= SLC_MSG_POWER_LIMIT;
            last_payload <= 10'h000;
        end else if (msg_valid) begin
            msg_count    <= msg_count + 1;
            last_code    <= msg_code;
            last_payload <= msg_payload;
        end
    end
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the slot register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Message checks go through the link peer's log
`timescale 1ns/100ps
module testbench import slc_pkg::*; ;
    logic          clk_sys, rstn, cfg_wr_en, cfg_rd_en, pres, cfg_rd_valid, notify, msg_valid;
    logic [11:0]   cfg_addr;
    logic [3:0]    cfg_byte_en;
    logic [31:0]   cfg_wdata, cfg_rdata;
    logic [9:0]    msg_payload, last_payload;
    slc_msg_code_t msg_code, last_code;
    int            msg_count, bad_count, checked, cyc;
    localparam logic [11:0] CAP = 12'h0b4;
    localparam logic [11:0] CTL = 12'h0b8;
    slc_slot_regs dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid), .presence_detect_pin(pres), .presence_notify(notify),
        .msg_valid(msg_valid), .msg_code(msg_code), .msg_payload(msg_payload));
    slc_link_peer peer (.clk_sys(clk_sys), .rstn(rstn), .msg_valid(msg_valid), .msg_code(msg_code),
        .msg_payload(msg_payload), .msg_count(msg_count), .last_code(last_code), .last_payload(last_payload));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Each access ends one edge later so the peer log has caught up
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_addr    = a;
        cfg_byte_en = be;
        cfg_wdata   = d;
        cfg_wr_en   = 1'b1;
        @(posedge clk_sys);
        #1 cfg_wr_en = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        cfg_addr  = a;
        cfg_rd_en = 1'b1;
        @(posedge clk_sys);
        #1 cfg_rd_en = 1'b0;
        chk("rd_valid", 32'h0000_0001, {31'h0, cfg_rd_valid});
        d = cfg_rdata;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic msg_chk(input int n0, input logic [1:0] c, input logic [9:0] p);
        chk("msg_count", 32'(n0 + 1), 32'(msg_count));
        chk("msg_code", {30'h0, c}, {30'h0, last_code});
        chk("msg_payload", {22'h0, p}, {22'h0, last_payload});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] d;
        rd(CAP, d);
        chk("cap_reset", 32'h0004_0000, d);
        rd(CTL, d);
        chk("ctl_reset", 32'h0000_01c0, d);
        $display("test reset done");
    endtask
    task automatic t_ind;
        logic [31:0] d;
        int          n;
        logic [1:0]  codes [3] = '{2'h2, 2'h1, 2'h3};
        foreach (codes[i]) begin
            n = msg_count;
            wr(CTL, 4'b0010, {22'h0, codes[i], 8'h00});
            msg_chk(n, codes[i], 10'h000);
            rd(CTL, d);
            chk("ind_state", {22'h0, codes[i], 8'hc0}, d);
        end
        n = msg_count;
        wr(CTL, 4'b0010, 32'h0000_0000);
        chk("rsv_no_msg", 32'(n), 32'(msg_count));
        rd(CTL, d);
        chk("rsv_keeps", 32'h0000_03c0, d);
        $display("test indicator done");
    endtask
    task automatic t_cap;
        logic [31:0] d;
        int          n;
        n = msg_count;
        wr(CAP, 4'hf, {13'h0a5b, 2'b01, 2'b11, 8'h96, 7'h7f});
        msg_chk(n, 2'h0, 10'h396);
        rd(CAP, d);
        chk("cap_first", {13'h0a5b, 2'b00, 2'b11, 8'h96, 7'h00}, d);
        wr(CAP, 4'hf, 32'hffff_ffff);
        chk("cap_lock_msg", 32'(n + 1), 32'(msg_count));
        rd(CAP, d);
        chk("cap_locked", {13'h0a5b, 2'b00, 2'b11, 8'h96, 7'h00}, d);
        $display("test capabilities done");
    endtask
    task automatic t_pres;
        logic [31:0] d;
        wr(CTL, 4'b0001, 32'h0000_0008);
        chk("notify_idle", 32'h0, {31'h0, notify});
        pres = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 rd(CTL, d);
        chk("pres_set", 32'h0048_03c8, d);
        chk("notify_on", 32'h1, {31'h0, notify});
        wr(CTL, 4'b0100, 32'h0008_0000);
        rd(CTL, d);
        chk("pres_clear", 32'h0040_03c8, d);
        chk("notify_clr", 32'h0, {31'h0, notify});
        wr(CTL, 4'b0001, 32'h0000_0000);
        pres = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 rd(CTL, d);
        chk("pres_masked", 32'h0008_03c0, d);
        chk("notify_mask", 32'h0, {31'h0, notify});
        wr(CTL, 4'b0001, 32'h0000_0008);
        chk("notify_late", 32'h1, {31'h0, notify});
        $display("test presence done");
    endtask
    task automatic t_unmap;
        logic [31:0] d;
        int          n;
        n = msg_count;
        wr(12'h0c0, 4'hf, 32'hffff_ffff);
        chk("unmap_msg", 32'(n), 32'(msg_count));
        rd(12'h0c0, d);
        chk("unmap_rd", 32'h0000_0000, d);
        $display("test unmapped done");
    endtask
    task automatic t_partial;
        logic [31:0] d;
        rstn = 1'b0;
        @(posedge clk_sys);
        #1 rstn = 1'b1;
        @(posedge clk_sys);
        #1 rd(CTL, d);
        chk("ctl_rerst", 32'h0000_01c0, d);
        wr(CAP, 4'b0100, 32'h00ff_0000);
        msg_chk(0, 2'h0, 10'h200);
        rd(CAP, d);
        chk("cap_part", 32'h00fd_0000, d);
        wr(CAP, 4'b0011, 32'hffff_ffff);
        chk("part_lock_msg", 32'h0000_0001, 32'(msg_count));
        rd(CAP, d);
        chk("part_locked", 32'h00fd_0000, d);
        $display("test partial capabilities done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Run is under a hundred cycles; the ceiling leaves ample room
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        {rstn, cfg_wr_en, cfg_rd_en, pres} = 4'h0;
        cfg_addr    = 12'h000;
        cfg_byte_en = 4'h0;
        cfg_wdata   = 32'h0000_0000;
        repeat (10) @(posedge clk_sys);
        #1 rstn = 1'b1;
        @(posedge clk_sys);
        #1 t_reset;
        t_ind;
        t_cap;
        t_pres;
        t_unmap;
        t_partial;
        wrap_up;
    end
endmodule
